// ==== mnbt_cpu_end.sv ====
// CPU end of the block-transfer unit: parameter registers, checks and word/byte mover.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Module read copies 1-128 bytes into memory.
// - Program puts base low, slot high byte.
// - Program puts byte count, max 128, level one.
// - Module read takes module address from accumulator.
// - Module read local start comes from operand.
// - Module write sends 1-128 bytes from operand.
// - Module write destination address is accumulator.
// - Bad parameters on any command set error flag; a command issued while a transfer runs is dropped without setting it.
// - Error flag holds until next command updates.
// - Parameters come from accumulator and two levels.
// - Program puts BCD station low, slot high.
// - Station zero accepted only for peer targets.
// - Program gives even BCD count 2-128.
// - Network read stores at accumulator master address.
// - Network read fetches slave data from operand.
// - Program issues network read only when relay off.
module mnbt_cpu_end
  import mnbt_pkg::*;
  #(
  parameter int MAX_BYTES = 128
  )
  (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Software register port, read data one cycle after the read strobe.
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [15:0]      reg_rdata_o,
  output logic             irq_o,
  // Variable memory, word wide, read data one cycle after the read strobe.
  output logic [15:0]      vm_addr_o,
  output logic [15:0]      vm_wdata_o,
  output logic             vm_we_o,
  output logic             vm_re_o,
  input  wire logic [15:0] vm_rdata_i,
  // Link.
  mnbt_link_if.cpu_end     link
  );

  if (MAX_BYTES < 2 || MAX_BYTES > 255)
  begin : g_bad_max
    $error("MAX_BYTES must lie between 2 and 255");
  end

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_REQ    = 3'b001,
    S_WFETCH = 3'b010,
    S_WLOAD  = 3'b011,
    S_WSEND  = 3'b100,
    S_RRECV  = 3'b101
  } mnbt_st_t;

  typedef struct packed {
    mnbt_st_t    st;
    logic [15:0] acc;
    logic [15:0] stk1;
    logic [15:0] stk2;
    logic [15:0] oper;
    logic        wr;
    logic        net;
    logic [15:0] far_addr;
    logic [15:0] loc_addr;
    logic [7:0]  left;
    logic        hi;
    logic [15:0] word;
    logic        perr;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic [15:0] rdata;
    logic [15:0] vm_addr;
    logic [15:0] vm_wdata;
    logic        vm_we;
    logic        vm_re;
    logic        req;
    logic        wr_valid;
    logic [7:0]  wr_data;
  } mnbt_cpu_t;

  mnbt_cpu_t   r_reg;
  mnbt_cpu_t   r_next;
  mnbt_op_t    op;
  logic        peer;
  logic        bad;
  logic [15:0] net_cnt;
  logic [7:0]  cnt;
  logic [1:0]  ev;

  // Checks run on the values held in the parameter registers at command time.
  always_comb
  begin
    op      = mnbt_op_t'(reg_wdata_i[CMD_OP_LSB +: 2]);
    peer    = reg_wdata_i[CMD_PEER_BIT];
    // Each digit is widened first so the tens product cannot wrap in four bits.
    net_cnt = 16'(r_reg.stk1[11:8]) * 16'h0064 + 16'(r_reg.stk1[7:4]) * 16'h000a +
              16'(r_reg.stk1[3:0]);
    bad     = 1'b0;
    cnt     = r_reg.stk1[7:0];
    if (r_reg.stk2[15:8] > SLOT_MAX)
    begin
      bad = 1'b1;
    end
    if (op == OP_RD_MOD || op == OP_WR_MOD)
    begin
      if (r_reg.stk2[7:0] > BASE_MAX) bad = 1'b1;
      if (r_reg.stk1 == WORD_RST || r_reg.stk1 > MOD_CNT_MAX ||
          r_reg.stk1 > 16'(MAX_BYTES)) bad = 1'b1;
    end
    else
    begin
      cnt = net_cnt[7:0];
      if (r_reg.stk2[7:4] > 4'h9 || r_reg.stk2[3:0] > 4'h9 ||
          r_reg.stk2[7:0] > STATION_MAX) bad = 1'b1;
      if (r_reg.stk2[7:0] == 8'h00 && !peer) bad = 1'b1;
      if (r_reg.stk1[15:12] != 4'h0 || r_reg.stk1[11:8] > 4'h9 ||
          r_reg.stk1[7:4] > 4'h9 || r_reg.stk1[3:0] > 4'h9 ||
          r_reg.stk1 < NET_CNT_MIN || r_reg.stk1 > NET_CNT_MAX ||
          net_cnt > 16'(MAX_BYTES) || r_reg.stk1[0]) bad = 1'b1;
    end
  end

  always_comb
  begin
    r_next        = r_reg;
    r_next.vm_we  = 1'b0;
    r_next.vm_re  = 1'b0;
    r_next.rdata  = WORD_RST;
    ev            = 2'b00;
    if (reg_re_i)
    begin
      case (reg_addr_i)
        REG_ACC:      r_next.rdata = r_reg.acc;
        REG_STK1:     r_next.rdata = r_reg.stk1;
        REG_STK2:     r_next.rdata = r_reg.stk2;
        REG_OPERAND:  r_next.rdata = r_reg.oper;
        REG_STATUS:   r_next.rdata = {13'h0000, link.module_busy_relay, r_reg.perr,
                                      r_reg.st != S_IDLE};
        REG_IRQ_STAT: r_next.rdata = {14'h0000, r_reg.irq_st};
        REG_IRQ_MASK: r_next.rdata = {14'h0000, r_reg.irq_mask};
        default:      r_next.rdata = WORD_RST;
      endcase
    end
    if (reg_we_i)
    begin
      case (reg_addr_i)
        REG_ACC:      r_next.acc = reg_wdata_i;
        REG_STK1:     r_next.stk1 = reg_wdata_i;
        REG_STK2:     r_next.stk2 = reg_wdata_i;
        REG_OPERAND:  r_next.oper = reg_wdata_i;
        REG_IRQ_STAT: r_next.irq_st = r_reg.irq_st & ~reg_wdata_i[1:0];
        REG_IRQ_MASK: r_next.irq_mask = reg_wdata_i[1:0];
        REG_CMD:
        begin
          // A command while a transfer runs is dropped and leaves the error flag alone.
          if (r_reg.st == S_IDLE)
          begin
            r_next.perr = bad;
            ev[IRQ_PERR_BIT] = bad;
            if (!bad)
            begin
              r_next.wr  = op[0];
              r_next.net = op[1];
              r_next.left = cnt;
              // Network commands swap the roles of accumulator and operand.
              r_next.far_addr = op[1] ? r_reg.oper : r_reg.acc;
              r_next.loc_addr = op[1] ? r_reg.acc : r_reg.oper;
              r_next.hi  = 1'b0;
              r_next.req = 1'b1;
              r_next.st  = S_REQ;
            end
          end
        end
        default:
        begin
        end
      endcase
    end
    case (r_reg.st)
      S_IDLE:
      begin
      end
      S_REQ:
      begin
        if (link.req_ack)
        begin
          r_next.req = 1'b0;
          if (r_reg.wr)
          begin
            r_next.vm_re   = 1'b1;
            r_next.vm_addr = r_reg.loc_addr;
            r_next.st      = S_WFETCH;
          end
          else
          begin
            r_next.st = S_RRECV;
          end
        end
      end
      S_WFETCH:
      begin
        r_next.st = S_WLOAD;
      end
      S_WLOAD:
      begin
        r_next.word     = vm_rdata_i;
        r_next.wr_data  = vm_rdata_i[7:0];
        r_next.wr_valid = 1'b1;
        r_next.hi       = 1'b0;
        r_next.st       = S_WSEND;
      end
      S_WSEND:
      begin
        if (link.wr_ready)
        begin
          r_next.left = r_reg.left - 8'h01;
          if (r_reg.left == 8'h01)
          begin
            r_next.wr_valid = 1'b0;
            ev[IRQ_DONE_BIT] = 1'b1;
            r_next.st = S_IDLE;
          end
          else if (!r_reg.hi)
          begin
            r_next.hi      = 1'b1;
            r_next.wr_data = r_reg.word[15:8];
          end
          else
          begin
            r_next.wr_valid = 1'b0;
            r_next.loc_addr = r_reg.loc_addr + 16'h0001;
            r_next.vm_addr  = r_reg.loc_addr + 16'h0001;
            r_next.vm_re    = 1'b1;
            r_next.st       = S_WFETCH;
          end
        end
      end
      S_RRECV:
      begin
        if (link.rd_valid)
        begin
          r_next.left = r_reg.left - 8'h01;
          if (!r_reg.hi && r_reg.left != 8'h01)
          begin
            r_next.word = {8'h00, link.rd_data};
            r_next.hi   = 1'b1;
          end
          else
          begin
            r_next.vm_we    = 1'b1;
            r_next.vm_addr  = r_reg.loc_addr;
            r_next.vm_wdata = r_reg.hi ? {link.rd_data, r_reg.word[7:0]}
                                       : {8'h00, link.rd_data};
            r_next.loc_addr = r_reg.loc_addr + 16'h0001;
            r_next.hi       = 1'b0;
          end
          if (r_reg.left == 8'h01)
          begin
            ev[IRQ_DONE_BIT] = 1'b1;
            r_next.st = S_IDLE;
          end
        end
      end
      default:
      begin
        r_next.st = S_IDLE;
      end
    endcase
    // Setting after the clear makes an event in the clearing cycle survive.
    r_next.irq_st = r_next.irq_st | ev;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      r_reg          <= '0;
      r_reg.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata_o    = r_reg.rdata;
  assign irq_o          = |(r_reg.irq_st & r_reg.irq_mask);
  assign vm_addr_o      = r_reg.vm_addr;
  assign vm_wdata_o     = r_reg.vm_wdata;
  assign vm_we_o        = r_reg.vm_we;
  assign vm_re_o        = r_reg.vm_re;
  assign link.req       = r_reg.req;
  assign link.req_write = r_reg.wr;
  assign link.req_net   = r_reg.net;
  assign link.req_sel   = r_reg.stk2[7:0];
  assign link.req_slot  = r_reg.stk2[10:8];
  assign link.req_addr  = r_reg.far_addr;
  assign link.req_count = r_reg.left;
  assign link.wr_valid  = r_reg.wr_valid;
  assign link.wr_data   = r_reg.wr_data;
  assign link.rd_ready  = (r_reg.st == S_RRECV);

endmodule : mnbt_cpu_end
`default_nettype wire

// ==== mnbt_far_end.sv ====
// Far end of the link: intelligent module or network master moving bytes to and from its own memory.
`timescale 1ns/1ps
`default_nettype none
module mnbt_far_end
  import mnbt_pkg::*;
  (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Link.
  mnbt_link_if.far_end     link,
  // Local byte memory, read data one cycle after the read strobe.
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Local status.
  input  wire logic        busy_i,
  output logic [7:0]       target_sel_o,
  output logic [2:0]       target_slot_o,
  output logic             target_net_o
  );

  typedef enum logic [2:0] {
    F_IDLE   = 3'b000,
    F_WR     = 3'b001,
    F_RFETCH = 3'b010,
    F_RLOAD  = 3'b011,
    F_RSEND  = 3'b100
  } mnbt_fst_t;

  typedef struct packed {
    mnbt_fst_t   st;
    logic [15:0] addr;
    logic [7:0]  left;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_we;
    logic        mem_re;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        busy;
    logic [7:0]  sel;
    logic [2:0]  slot;
    logic        net;
  } mnbt_far_t;

  mnbt_far_t r_reg;
  mnbt_far_t r_next;
  logic      ack;

  // A request is taken only while this end is idle and its owner is not busy.
  assign ack = (r_reg.st == F_IDLE) && link.req && !busy_i;

  always_comb
  begin
    r_next        = r_reg;
    r_next.mem_we = 1'b0;
    r_next.mem_re = 1'b0;
    case (r_reg.st)
      F_IDLE:
      begin
        if (ack)
        begin
          r_next.addr = link.req_addr;
          r_next.left = link.req_count;
          r_next.sel  = link.req_sel;
          r_next.slot = link.req_slot;
          r_next.net  = link.req_net;
          if (link.req_write)
          begin
            r_next.st = F_WR;
          end
          else
          begin
            r_next.mem_re   = 1'b1;
            r_next.mem_addr = link.req_addr;
            r_next.st       = F_RFETCH;
          end
        end
      end
      F_WR:
      begin
        if (link.wr_valid)
        begin
          r_next.mem_we    = 1'b1;
          r_next.mem_addr  = r_reg.addr;
          r_next.mem_wdata = link.wr_data;
          r_next.addr      = r_reg.addr + 16'h0001;
          r_next.left      = r_reg.left - 8'h01;
          if (r_reg.left == 8'h01)
          begin
            r_next.st = F_IDLE;
          end
        end
      end
      F_RFETCH:
      begin
        r_next.st = F_RLOAD;
      end
      F_RLOAD:
      begin
        r_next.rd_data  = mem_rdata_i;
        r_next.rd_valid = 1'b1;
        r_next.st       = F_RSEND;
      end
      F_RSEND:
      begin
        if (link.rd_ready)
        begin
          r_next.rd_valid = 1'b0;
          r_next.left     = r_reg.left - 8'h01;
          if (r_reg.left == 8'h01)
          begin
            r_next.st = F_IDLE;
          end
          else
          begin
            r_next.addr     = r_reg.addr + 16'h0001;
            r_next.mem_addr = r_reg.addr + 16'h0001;
            r_next.mem_re   = 1'b1;
            r_next.st       = F_RFETCH;
          end
        end
      end
      default:
      begin
        r_next.st = F_IDLE;
      end
    endcase
    r_next.busy = busy_i || (r_next.st != F_IDLE);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign link.req_ack           = ack;
  assign link.wr_ready          = (r_reg.st == F_WR);
  assign link.rd_valid          = r_reg.rd_valid;
  assign link.rd_data           = r_reg.rd_data;
  assign link.module_busy_relay = r_reg.busy;
  assign mem_addr_o             = r_reg.mem_addr;
  assign mem_wdata_o            = r_reg.mem_wdata;
  assign mem_we_o               = r_reg.mem_we;
  assign mem_re_o               = r_reg.mem_re;
  assign target_sel_o           = r_reg.sel;
  assign target_slot_o          = r_reg.slot;
  assign target_net_o           = r_reg.net;

endmodule : mnbt_far_end
`default_nettype wire

// ==== mnbt_link_if.sv ====
// Backplane link between the command unit and the intelligent module or network master.
`timescale 1ns/1ps
`default_nettype none
interface mnbt_link_if
  (
  input wire logic core_clk_i,
  input wire logic rst_i
  );
  logic        req;
  logic        req_write;
  logic        req_net;
  logic [7:0]  req_sel;
  logic [2:0]  req_slot;
  logic [15:0] req_addr;
  logic [7:0]  req_count;
  logic        req_ack;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        wr_ready;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        rd_ready;
  logic        module_busy_relay;

  modport cpu_end
    (
    output req, req_write, req_net, req_sel, req_slot, req_addr, req_count,
    input  req_ack,
    output wr_valid, wr_data,
    input  wr_ready,
    input  rd_valid, rd_data,
    output rd_ready,
    input  module_busy_relay
    );

  modport far_end
    (
    input  req, req_write, req_net, req_sel, req_slot, req_addr, req_count,
    output req_ack,
    input  wr_valid, wr_data,
    output wr_ready,
    output rd_valid, rd_data,
    input  rd_ready,
    output module_busy_relay
    );
endinterface : mnbt_link_if
`default_nettype wire

// ==== mnbt_monitor.sv ====
// Checker watching the link between the command unit and its far end.
`timescale 1ns/1ps
`default_nettype none
module mnbt_monitor
  (
  // Clock and reset.
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // Link.
  input wire logic        req,
  input wire logic        req_write,
  input wire logic        req_net,
  input wire logic [7:0]  req_sel,
  input wire logic [2:0]  req_slot,
  input wire logic [15:0] req_addr,
  input wire logic [7:0]  req_count,
  input wire logic        req_ack,
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_ready,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_ready,
  input wire logic        module_busy_relay
  );
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  req_hold_a:
    assert property (req && !req_ack |=> req && $stable(req_addr) && $stable(req_count)
      && $stable(req_sel) && $stable(req_write)) else $error("request changed early");
  ack_drop_a:
    assert property (req && req_ack |=> !req) else $error("request held after ack");
  relay_on_a:
    assert property (req && req_ack |-> ##[1:2] module_busy_relay) else $error("relay low");
  mod_params_a:
    assert property (req && !req_net |-> req_count >= 8'h01 && req_count <= 8'h80
      && req_sel <= 8'h03) else $error("bad module request sent");
  net_count_a:
    assert property (req && req_net |-> req_count >= 8'h02 && req_count <= 8'h80
      && !req_count[0]) else $error("bad network count sent");
  net_station_a:
    assert property (req && req_net |-> req_sel <= 8'h90 && req_sel[3:0] <= 4'h9)
      else $error("bad station sent");
  wr_hold_a:
    assert property (wr_valid |-> wr_ready)
      else $error("write byte offered while far end not receiving");
  rd_hold_a:
    assert property (rd_valid |-> rd_ready)
      else $error("read byte offered while command unit not receiving");
endmodule : mnbt_monitor
`default_nettype wire

// ==== mnbt_pkg.sv ====
// Shared constants and types for the block-transfer command unit and its far end.
package mnbt_pkg;

  // Commands written to the command register.
  typedef enum logic [1:0] {
    OP_RD_MOD = 2'b00,
    OP_WR_MOD = 2'b01,
    OP_RD_NET = 2'b10,
    OP_WR_NET = 2'b11
  } mnbt_op_t;

  // Register indices on the software port.
  localparam logic [3:0] REG_ACC      = 4'h0;
  localparam logic [3:0] REG_STK1     = 4'h1;
  localparam logic [3:0] REG_STK2     = 4'h2;
  localparam logic [3:0] REG_OPERAND  = 4'h3;
  localparam logic [3:0] REG_CMD      = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;

  // Field positions.
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_PEER_BIT  = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PERR_BIT = 1;
  localparam int STAT_RLY_BIT  = 2;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_PERR_BIT  = 1;

  // Parameter limits.
  localparam logic [7:0]  BASE_MAX      = 8'h03;
  localparam logic [7:0]  SLOT_MAX      = 8'h07;
  localparam logic [7:0]  STATION_MAX   = 8'h90;
  localparam logic [15:0] MOD_CNT_MAX   = 16'h0080;
  localparam logic [15:0] NET_CNT_MIN   = 16'h0002;
  localparam logic [15:0] NET_CNT_MAX   = 16'h0128;

  // Reset values.
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

endpackage : mnbt_pkg

// ==== test_module_network_block_transfer.sv ====
// Self-checking bench joining the command unit to its far end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(g, e)
module test_module_network_block_transfer
  import mnbt_pkg::*;
  ;
  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_we_i    = 1'b0;
  logic        reg_re_i    = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        irq_o;
  logic [15:0] vm_addr_o;
  logic [15:0] vm_wdata_o;
  logic        vm_we_o;
  logic        vm_re_o;
  logic [15:0] vm_rdata_i  = 16'h0000;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_wdata_o;
  logic        mem_we_o;
  logic        mem_re_o;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic        busy_i      = 1'b0;
  logic [7:0]  target_sel_o;
  logic [2:0]  target_slot_o;
  logic        target_net_o;
  logic [15:0] vmem [0:65535];
  logic [7:0]  fmem [0:65535];
  int          miscompares = 0;
  int          checks_done = 0;
  logic [15:0] bad_tab [0:10][0:2] = '{
    '{16'h0000, 16'h0000, 16'h0201}, '{16'h0001, 16'h0081, 16'h0201},
    '{16'h0000, 16'h0010, 16'h0204}, '{16'h0001, 16'h0010, 16'h0801},
    '{16'h0002, 16'h0010, 16'h0200}, '{16'h0003, 16'h0010, 16'h0291},
    '{16'h0002, 16'h0010, 16'h021a}, '{16'h0002, 16'h0003, 16'h0205},
    '{16'h0003, 16'h0130, 16'h0205}, '{16'h0002, 16'h001a, 16'h0205},
    '{16'h0003, 16'h0000, 16'h0205}};

  always #2 core_clk_i = ~core_clk_i;

  mnbt_link_if link (.core_clk_i(core_clk_i), .rst_i(rst_i));
  mnbt_cpu_end mnbt_cpu_end_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .vm_addr_o(vm_addr_o),
    .vm_wdata_o(vm_wdata_o), .vm_we_o(vm_we_o), .vm_re_o(vm_re_o),
    .vm_rdata_i(vm_rdata_i), .link(link));
  mnbt_far_end mnbt_far_end_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i), .busy_i(busy_i),
    .target_sel_o(target_sel_o), .target_slot_o(target_slot_o),
    .target_net_o(target_net_o));
  mnbt_monitor mnbt_monitor_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req(link.req),
    .req_write(link.req_write), .req_net(link.req_net), .req_sel(link.req_sel),
    .req_slot(link.req_slot), .req_addr(link.req_addr), .req_count(link.req_count),
    .req_ack(link.req_ack), .wr_valid(link.wr_valid), .wr_data(link.wr_data),
    .wr_ready(link.wr_ready), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
    .rd_ready(link.rd_ready), .module_busy_relay(link.module_busy_relay));

  // Idle read data is inverted each cycle so a late sample never looks valid.
  always @(posedge core_clk_i)
  begin
    if (vm_we_o)
      vmem[vm_addr_o] <= vm_wdata_o;
    vm_rdata_i <= vm_re_o ? vmem[vm_addr_o] : ~vm_rdata_i;
    if (mem_we_o)
      fmem[mem_addr_o] <= mem_wdata_o;
    mem_rdata_i <= mem_re_o ? fmem[mem_addr_o] : ~mem_rdata_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  function automatic logic [7:0] exp_byte(input logic [15:0] loc, input int i);
    return i[0] ? vmem[loc + i / 2][15:8] : vmem[loc + i / 2][7:0];
  endfunction : exp_byte

  function automatic logic [15:0] exp_word(input logic [15:0] far, input int k, input int n);
    return {(2 * k + 1 < n) ? fmem[far + 2 * k + 1] : 8'h00, fmem[far + 2 * k]};
  endfunction : exp_word

  function automatic logic [15:0] bcd(input int n);
    return 16'((n / 100) * 256 + ((n / 10) % 10) * 16 + n % 10);
  endfunction : bcd

  task automatic xfer(input mnbt_op_t op, input logic peer, input logic [7:0] sel,
                      input logic [7:0] slot, input int n, input logic stall);
    logic [15:0] acc, opd, far, loc, v, sent, mask;
    int k;
    acc  = 16'($urandom_range(0, 65024));
    opd  = 16'($urandom_range(0, 65024));
    far  = op[1] ? opd : acc;
    loc  = op[1] ? acc : opd;
    mask = 16'($urandom_range(0, 3));
    v    = 16'h0000;
    for (k = 0; k < n + 2; k++)
    begin
      fmem[far + k] = 8'($urandom);
      vmem[loc + k] = 16'($urandom);
    end
    sent = op[0] ? 16'(fmem[far + n]) : vmem[loc + (n + 1) / 2];
    // A network read is only issued while the relay is off, so it never stalls.
    stall = stall && op != OP_RD_NET;
    @(posedge core_clk_i);
    busy_i <= stall;
    wr(REG_IRQ_MASK, mask);
    wr(REG_ACC, acc);
    wr(REG_STK1, op[1] ? bcd(n) : 16'(n));
    wr(REG_STK2, {slot, sel});
    wr(REG_OPERAND, opd);
    wr(REG_CMD, {13'h0000, peer, op});
    if (stall)
    begin
      rd(REG_STATUS, v);
      `CHK(v, 16'h0005);
      `CHK({link.req, link.req_ack}, 2'b10);
      v = 16'h0000;
      @(posedge core_clk_i);
      busy_i <= 1'b0;
    end
    for (k = 0; k < 3000 && !v[IRQ_DONE_BIT]; k++)
      rd(REG_IRQ_STAT, v);
    if (!v[IRQ_DONE_BIT])
    begin
      miscompares++;
      results();
    end
    `CHK(v, 16'h0001);
    `CHK(irq_o, mask[0]);
    rd(REG_STATUS, v);
    `CHK(v, 16'h0000);
    `CHK({target_net_o, target_slot_o, target_sel_o}, {op[1], slot[2:0], sel});
    for (k = 0; k < n; k++)
      if (op[0])
        `CHK(fmem[far + k], exp_byte(loc, k));
    for (k = 0; k < (n + 1) / 2; k++)
      if (!op[0])
        `CHK(vmem[loc + k], exp_word(far, k, n));
    `CHK(op[0] ? 16'(fmem[far + n]) : vmem[loc + (n + 1) / 2], sent);
    wr(REG_IRQ_STAT, 16'h0003);
    rd(REG_IRQ_STAT, v);
    `CHK({v, irq_o}, 17'h00000);
    $display("transfer op %0d of %0d bytes done", op, n);
  endtask : xfer

  task automatic bad(input logic [15:0] cmd, input logic [15:0] cnt, input logic [15:0] stk2);
    logic [15:0] v;
    wr(REG_IRQ_MASK, 16'h0002);
    wr(REG_STK1, cnt);
    wr(REG_STK2, stk2);
    wr(REG_CMD, cmd);
    rd(REG_STATUS, v);
    `CHK(v, 16'h0002);
    `CHK({link.req, irq_o}, 2'b01);
    rd(REG_IRQ_STAT, v);
    `CHK(v, 16'h0002);
    wr(REG_IRQ_STAT, 16'h0002);
    rd(REG_STATUS, v);
    `CHK(v, 16'h0002);
    $display("refused command %h count %h", cmd, cnt);
  endtask : bad

  initial
  begin
    logic [15:0] v;
    mnbt_op_t    op;
    int          i;
    int          n;
    void'($urandom(55));
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS, v);
    `CHK(v, 16'h0000);
    rd(REG_IRQ_MASK, v);
    `CHK(v, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, v);
    `CHK(v, 16'h0000);
    $display("reset values done");
    xfer(OP_WR_MOD, 1'b0, 8'h03, 8'h07, 1, 1'b0);
    xfer(OP_RD_MOD, 1'b0, 8'h00, 8'h00, 128, 1'b0);
    xfer(OP_RD_MOD, 1'b0, 8'h01, 8'h02, 5, 1'b1);
    xfer(OP_WR_MOD, 1'b0, 8'h02, 8'h03, 128, 1'b0);
    xfer(OP_RD_NET, 1'b0, 8'h90, 8'h07, 128, 1'b0);
    xfer(OP_WR_NET, 1'b1, 8'h00, 8'h02, 2, 1'b1);
    for (i = 0; i < 11; i++)
    begin
      bad(bad_tab[i][0], bad_tab[i][1], bad_tab[i][2]);
      op = mnbt_op_t'($urandom_range(0, 3));
      n  = op[1] ? 2 * $urandom_range(1, 64) : $urandom_range(1, 128);
      xfer(op, 1'b0, op[1] ? 8'(bcd($urandom_range(1, 90))) : 8'($urandom_range(0, 3)),
           8'($urandom_range(0, 7)), n, 1'($urandom_range(0, 1)));
    end
    results();
  end
endmodule : test_module_network_block_transfer
`default_nettype wire
